// [fbu_pkg.sv]
`default_nettype none
package fbu_pkg;
    // Bus and character geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CHAR_W = 8;
    localparam int unsigned CNT_W = 3;
    localparam int unsigned DEPTH = 4;
    localparam int unsigned DIV_W = 16;
    localparam int unsigned ACC_W = 17;

    // Bus clock and the four reference rates, in Hz
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned REF0_HZ = 10_000_000;
    localparam int unsigned REF1_HZ = 5_000_000;
    localparam int unsigned REF2_HZ = 2_500_000;
    localparam int unsigned REF3_HZ = 1_250_000;

    // Prescaler masks, one per reference select
    localparam logic [2:0] PRE0 = 3'(CLK_HZ / REF0_HZ - 1);
    localparam logic [2:0] PRE1 = 3'(CLK_HZ / REF1_HZ - 1);
    localparam logic [2:0] PRE2 = 3'(CLK_HZ / REF2_HZ - 1);
    localparam logic [2:0] PRE3 = 3'(CLK_HZ / REF3_HZ - 1);

    // Divider in eighths: 13 integer and 3 fraction bits
    localparam int unsigned FRAC_W = 3;
    localparam logic [16:0] TX_STEP = 17'h00008;
    localparam logic [16:0] RX_STEP = 17'h00010;
    localparam logic [15:0] DIV_MIN = 16'h0040;
    localparam logic [15:0] DIV_FLOOR = 16'h0010;
    localparam logic [15:0] BAUD_RST = 16'h0040;

    // Register byte offsets
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_BAUD = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0c;
    localparam logic [7:0] OFF_IEN = 8'h10;

    // Status bit positions
    localparam int unsigned STAT_CNT_LSB = 0;
    localparam int unsigned STAT_TXF = 3;
    localparam int unsigned STAT_TXE = 4;
    localparam int unsigned STAT_PERR = 5;
    localparam int unsigned STAT_FERR = 6;
    localparam int unsigned STAT_OERR = 7;

    // Interrupt enable positions
    localparam int unsigned IEN_RXA = 0;
    localparam int unsigned IEN_PERR = 1;
    localparam int unsigned IEN_FERR = 2;
    localparam int unsigned IEN_OERR = 3;
    localparam logic [3:0] IEN_RST = 4'h0;

    typedef enum logic [1:0] {
        PAR_ODD = 2'h0,
        PAR_EVEN = 2'h1,
        PAR_MARK = 2'h2,
        PAR_SPACE = 2'h3
    } fbu_par_t;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_START = 5'h02,
        S_DATA = 5'h04,
        S_PAR = 5'h08,
        S_STOP = 5'h10
    } fbu_ser_t;

    // Control register layout, bit 0 upward: sel, len7, pen, ptype, stop2
    typedef struct packed {
        logic stop2;
        fbu_par_t ptype;
        logic pen;
        logic len7;
        logic [1:0] sel;
    } fbu_ctrl_t;

    localparam fbu_ctrl_t CTRL_RST = fbu_ctrl_t'(7'h00);

    typedef struct packed {
        logic [DEPTH-1:0][CHAR_W-1:0] mem;
        logic [1:0] wp;
        logic [1:0] rp;
        logic [CNT_W-1:0] cnt;
        logic [CHAR_W-1:0] rd;
    } fbu_fifo_st_t;

    typedef struct packed {
        fbu_ctrl_t ctrl;
        logic [DIV_W-1:0] div;
        logic [3:0] ien;
        logic perr;
        logic ferr;
        logic oerr;
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
        logic irq;
        logic [2:0] pre;
        logic rx_s1;
        logic rx_s2;
        logic rx_s3;
        fbu_ser_t rx_st;
        logic [ACC_W-1:0] rx_acc;
        logic rx_ph;
        logic [2:0] rx_bit;
        logic [CHAR_W-1:0] rx_sh;
        logic rx_pbad;
        fbu_ser_t tx_st;
        logic [ACC_W-1:0] tx_acc;
        logic [2:0] tx_bit;
        logic [CHAR_W-1:0] tx_sh;
        logic [CHAR_W-1:0] tx_char;
        logic tx_stop2nd;
        logic txd;
    } fbu_st_t;

    localparam fbu_st_t ST_RST = '{
        ctrl: CTRL_RST, div: BAUD_RST, ien: IEN_RST,
        rx_s1: 1'b1, rx_s2: 1'b1, rx_s3: 1'b1,
        rx_st: S_IDLE, tx_st: S_IDLE, txd: 1'b1,
        default: '0
    };
endpackage
`default_nettype wire

// [fbu_fifo_if.sv]
`default_nettype none
interface fbu_fifo_if;
    logic push;
    logic [7:0] wdata;
    logic pop;
    logic [7:0] rdata;
    logic [2:0] count;
    logic full;
    logic empty;
    modport mem (input push, wdata, pop, output rdata, count, full, empty);
    modport user (output push, wdata, pop, input rdata, count, full, empty);
endinterface
`default_nettype wire

// [fbu_fifo.sv]
`default_nettype none
module fbu_fifo (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, active low
    fbu_fifo_if.mem f // Push, pop and head
);
    fbu_pkg::fbu_fifo_st_t r, n;
    logic do_pop, do_push;

    // Pop when not empty, push when room or popping together
    assign do_pop = f.pop && (r.cnt != 3'h0);
    assign do_push = f.push && ((r.cnt != 3'(fbu_pkg::DEPTH)) || do_pop);

    // Next pointers, storage and registered head
    always_comb begin
        n = r;
        if (do_push) begin
            n.mem[r.wp] = f.wdata;
            n.wp = r.wp + 2'h1;
        end
        if (do_pop) begin
            n.rp = r.rp + 2'h1;
        end
        n.cnt = r.cnt + 3'(do_push) - 3'(do_pop);
        n.rd = n.mem[n.rp];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign f.rdata = r.rd;
    assign f.count = r.cnt;
    assign f.full = (r.cnt == 3'(fbu_pkg::DEPTH));
    assign f.empty = (r.cnt == 3'h0);

    chk_fifo_bound: assert property (@(posedge pclk) disable iff (!presetn)
        r.cnt <= 3'(fbu_pkg::DEPTH))
        else $error("fifo count above depth");
endmodule // fbu_fifo
`default_nettype wire

// [fbu_uart.sv]
// What this block does
// - Software picks the reference clock: 10, 5, 2.5 or 1.25 MHz.
// - The divider holds 13 integer and 3 fraction bits.
// - Divide values below 8.0 are outside normal use; 1.25 MBd tops out.
// - Characters carry seven or eight data bits, same at both ends.
// - Optional parity of odd, even, mark or space kind, sent and checked.
// - Each sent character ends in one or two stop bits.
// - Status shows how many received characters wait in the buffer.
// - Receive errors show in status and can raise an interrupt.
// - The link is one serial input and one serial output only.
// - The block is the terminal end: sends on txd, listens on rxd.
`default_nettype none
module fbu_uart (
    input wire logic pclk, // Bus clock, 10 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic rxd, // Serial input
    output logic txd, // Serial output
    output logic irq // Interrupt request
);
    fbu_pkg::fbu_st_t r, n;
    fbu_fifo_if rxf ();
    fbu_fifo_if txf ();
    logic acc_en, done, ref_tick, tx_tick, rx_tick, sample;
    logic [16:0] tx_sum, rx_sum, eff_div;
    logic [2:0] last_bit;
    logic [7:0] rx_word, stat;
    logic [3:0] ev;
    logic rx_push, rx_pop, tx_push, tx_pop;

    // Parity bit for a character under the current framing
    function automatic logic par_bit(input logic [7:0] d,
                                     input fbu_pkg::fbu_ctrl_t c);
        logic [7:0] m;
        m = c.len7 ? {1'b0, d[6:0]} : d;
        case (c.ptype)
            fbu_pkg::PAR_ODD: par_bit = ~^m;
            fbu_pkg::PAR_EVEN: par_bit = ^m;
            fbu_pkg::PAR_MARK: par_bit = 1'b1;
            default: par_bit = 1'b0;
        endcase
    endfunction

    // Prescaler mask for the chosen reference rate
    function automatic logic [2:0] pre_mask(input logic [1:0] s);
        case (s)
            2'h0: pre_mask = fbu_pkg::PRE0;
            2'h1: pre_mask = fbu_pkg::PRE1;
            2'h2: pre_mask = fbu_pkg::PRE2;
            default: pre_mask = fbu_pkg::PRE3;
        endcase
    endfunction

    fbu_fifo u_rx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .f(rxf.mem)
    );

    fbu_fifo u_tx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .f(txf.mem)
    );

    // Bus phases: decide in first access cycle, complete in the next
    assign acc_en = psel && penable && !r.pready;
    assign done = psel && penable && r.pready;

    // Reference tick and fractional baud ticks
    assign ref_tick = (r.pre & pre_mask(r.ctrl.sel)) == 3'h0;
    assign eff_div = {1'b0, (r.div < fbu_pkg::DIV_FLOOR) ?
                      fbu_pkg::DIV_FLOOR : r.div};
    assign tx_sum = r.tx_acc + fbu_pkg::TX_STEP;
    assign rx_sum = r.rx_acc + fbu_pkg::RX_STEP;
    assign tx_tick = ref_tick && (tx_sum >= eff_div);
    assign rx_tick = ref_tick && (rx_sum >= eff_div);
    assign sample = rx_tick && !r.rx_ph && (r.rx_st != fbu_pkg::S_IDLE);

    // Framing helpers
    assign last_bit = r.ctrl.len7 ? 3'h6 : 3'h7;
    assign rx_word = r.ctrl.len7 ? {1'b0, r.rx_sh[7:1]} : r.rx_sh;
    assign stat = {r.oerr, r.ferr, r.perr, txf.empty, txf.full,
                   rxf.count};

    // Buffer connections
    assign rxf.push = rx_push;
    assign rxf.wdata = rx_word;
    assign rxf.pop = rx_pop;
    assign txf.push = tx_push;
    assign txf.wdata = pwdata[7:0];
    assign txf.pop = tx_pop;

    // Next state of the whole block
    always_comb begin
        n = r;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        n.pre = r.pre + 3'h1;

        // Bus read decode and answer
        n.pready = acc_en;
        if (acc_en) begin
            n.pslverr = 1'b0;
            n.prdata = '0;
            case (paddr)
                fbu_pkg::OFF_DATA: n.prdata = {24'h000000, rxf.rdata};
                fbu_pkg::OFF_CTRL: n.prdata = {25'h0000000, r.ctrl};
                fbu_pkg::OFF_BAUD: n.prdata = {16'h0000, r.div};
                fbu_pkg::OFF_STAT: n.prdata = {24'h000000, stat};
                fbu_pkg::OFF_IEN: n.prdata = {28'h0000000, r.ien};
                default: n.pslverr = 1'b1;
            endcase
            if (pwrite) begin
                n.prdata = '0;
            end
        end

        // Bus write effects and read side effects
        if (done && pwrite) begin
            case (paddr)
                fbu_pkg::OFF_DATA: tx_push = !txf.full;
                fbu_pkg::OFF_CTRL: n.ctrl = fbu_pkg::fbu_ctrl_t'(pwdata[6:0]);
                fbu_pkg::OFF_BAUD: n.div = pwdata[15:0];
                fbu_pkg::OFF_IEN: n.ien = pwdata[3:0];
                fbu_pkg::OFF_STAT: begin
                    n.perr = r.perr && !pwdata[fbu_pkg::STAT_PERR];
                    n.ferr = r.ferr && !pwdata[fbu_pkg::STAT_FERR];
                    n.oerr = r.oerr && !pwdata[fbu_pkg::STAT_OERR];
                end
                default: n.div = r.div;
            endcase
        end
        if (done && !pwrite && (paddr == fbu_pkg::OFF_DATA)) begin
            rx_pop = 1'b1;
        end

        // Input synchroniser and edge history
        n.rx_s1 = rxd;
        n.rx_s2 = r.rx_s1;
        n.rx_s3 = r.rx_s2;

        // Transmit bit clock, free running
        if (ref_tick) begin
            n.tx_acc = tx_tick ? tx_sum - eff_div : tx_sum;
        end

        // Transmit framing
        if (tx_tick) begin
            case (r.tx_st)
                fbu_pkg::S_IDLE: begin
                    n.txd = 1'b1;
                    if (!txf.empty) begin
                        tx_pop = 1'b1;
                        n.tx_char = txf.rdata;
                        n.tx_sh = txf.rdata;
                        n.txd = 1'b0;
                        n.tx_st = fbu_pkg::S_START;
                    end
                end
                fbu_pkg::S_START: begin
                    n.txd = r.tx_sh[0];
                    n.tx_sh = {1'b0, r.tx_sh[7:1]};
                    n.tx_bit = 3'h0;
                    n.tx_st = fbu_pkg::S_DATA;
                end
                fbu_pkg::S_DATA: begin
                    if (r.tx_bit == last_bit) begin
                        n.tx_stop2nd = 1'b0;
                        if (r.ctrl.pen) begin
                            n.txd = par_bit(r.tx_char, r.ctrl);
                            n.tx_st = fbu_pkg::S_PAR;
                        end else begin
                            n.txd = 1'b1;
                            n.tx_st = fbu_pkg::S_STOP;
                        end
                    end else begin
                        n.txd = r.tx_sh[0];
                        n.tx_sh = {1'b0, r.tx_sh[7:1]};
                        n.tx_bit = r.tx_bit + 3'h1;
                    end
                end
                fbu_pkg::S_PAR: begin
                    n.txd = 1'b1;
                    n.tx_st = fbu_pkg::S_STOP;
                end
                fbu_pkg::S_STOP: begin
                    n.txd = 1'b1;
                    if (r.ctrl.stop2 && !r.tx_stop2nd) begin
                        n.tx_stop2nd = 1'b1;
                    end else begin
                        n.tx_st = fbu_pkg::S_IDLE;
                    end
                end
                default: begin
                    n.txd = 1'b1;
                    n.tx_st = fbu_pkg::S_IDLE;
                end
            endcase
        end

        // Receive half-bit clock, restarted at each start edge
        if (r.rx_st == fbu_pkg::S_IDLE) begin
            n.rx_acc = '0;
            n.rx_ph = 1'b0;
            if (r.rx_s3 && !r.rx_s2) begin
                n.rx_st = fbu_pkg::S_START;
                n.rx_pbad = 1'b0;
            end
        end else if (ref_tick) begin
            n.rx_acc = rx_tick ? rx_sum - eff_div : rx_sum;
            if (rx_tick) begin
                n.rx_ph = !r.rx_ph;
            end
        end

        // Receive framing, sampled at mid bit
        if (sample) begin
            case (r.rx_st)
                fbu_pkg::S_START: begin
                    n.rx_bit = 3'h0;
                    n.rx_sh = '0;
                    n.rx_st = r.rx_s2 ? fbu_pkg::S_IDLE : fbu_pkg::S_DATA;
                end
                fbu_pkg::S_DATA: begin
                    n.rx_sh = {r.rx_s2, r.rx_sh[7:1]};
                    n.rx_bit = r.rx_bit + 3'h1;
                    if (r.rx_bit == last_bit) begin
                        n.rx_st = r.ctrl.pen ? fbu_pkg::S_PAR
                                             : fbu_pkg::S_STOP;
                    end
                end
                fbu_pkg::S_PAR: begin
                    n.rx_pbad = r.rx_s2 != par_bit(rx_word, r.ctrl);
                    n.rx_st = fbu_pkg::S_STOP;
                end
                fbu_pkg::S_STOP: begin
                    n.rx_st = fbu_pkg::S_IDLE;
                    if (r.rx_pbad && r.ctrl.pen) begin
                        n.perr = 1'b1;
                    end
                    if (!r.rx_s2) begin
                        n.ferr = 1'b1;
                    end
                    if (rxf.full && !rx_pop) begin
                        n.oerr = 1'b1;
                    end else begin
                        rx_push = 1'b1;
                    end
                end
                default: n.rx_st = fbu_pkg::S_IDLE;
            endcase
        end

        // Interrupt from enabled status events, in enable order
        ev = {n.oerr, n.ferr, n.perr, rxf.count != 3'h0};
        n.irq = |(n.ien & ev);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= fbu_pkg::ST_RST;
        end else begin
            r <= n;
        end
    end

    // Ports straight from the state register
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign txd = r.txd;
    assign irq = r.irq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_ref_slowest: assert property (
        (ref_tick && r.ctrl.sel == 2'h3) |=>
        (!ref_tick || r.ctrl.sel != 2'h3) [*7])
        else $error("slowest reference ticks too often");

    chk_div_residue: assert property (
        (tx_tick && r.tx_acc < eff_div) |=>
        (r.tx_acc < fbu_pkg::TX_STEP))
        else $error("divider residue out of range");

    chk_div_min_rate: assert property (
        (tx_tick && r.ctrl.sel == 2'h0 && r.div >= fbu_pkg::DIV_MIN &&
         r.tx_acc < eff_div) |=>
        (!tx_tick) [*7])
        else $error("bit clock faster than divide of 8.0");

    chk_data_len: assert property (
        (r.tx_st == fbu_pkg::S_DATA) |-> (r.tx_bit <= last_bit))
        else $error("too many data bits");

    chk_parity_out: assert property (
        (r.tx_st == fbu_pkg::S_PAR) |->
        (txd == par_bit(r.tx_char, r.ctrl)))
        else $error("wrong parity bit sent");

    chk_stop_high: assert property (
        (r.tx_st == fbu_pkg::S_STOP || r.tx_st == fbu_pkg::S_IDLE)
        |-> txd)
        else $error("stop or idle not high");

    chk_start_low: assert property (
        (r.tx_st == fbu_pkg::S_START) |-> !txd)
        else $error("start bit not low");

    chk_rx_count: assert property (
        (acc_en && !pwrite && paddr == fbu_pkg::OFF_STAT) |=>
        (pready && prdata[2:0] == $past(rxf.count)))
        else $error("receive count misreported");

    chk_overrun_set: assert property (
        (sample && r.rx_st == fbu_pkg::S_STOP && rxf.full && !rx_pop)
        |=> r.oerr)
        else $error("overrun not flagged");

    chk_irq_follow: assert property (
        (r.ien[fbu_pkg::IEN_FERR] && r.ferr && !done) |=> irq)
        else $error("enabled error raised no interrupt");

    cov_tx_parity: cover property (
        r.tx_st == fbu_pkg::S_PAR ##[1:300] r.tx_st == fbu_pkg::S_IDLE);
    cov_rx_push: cover property (rx_push);
    cov_rx_full: cover property (rxf.full && sample);
    cov_err_read: cover property (done && paddr == fbu_pkg::OFF_STAT);
endmodule // fbu_uart
`default_nettype wire

// [fbu_uart_end.sv]
`default_nettype none
`default_nettype wire

// [fbu_host.sv]
`default_nettype none
// Host serial port: frames characters onto rxd, decodes txd
module fbu_host (
    input wire logic txd, // Line from the block
    output logic rxd // Line into the block
);
    timeunit 1ns;
    timeprecision 1ps;
    real bit_ns = 800.0;
    int nbits = 8;
    bit pen = 1'b0;
    logic [9:0] got[$];
    logic [9:0] w;
    initial rxd = 1'b1;
    // Decode a frame: data, parity into bit 8, stop into bit 9
    always begin
        @(negedge txd);
        #(bit_ns / 2.0);
        w = '0;
        if (txd === 1'b0) begin
            for (int i = 0; i < nbits; i++) begin
                #(bit_ns);
                w[i] = txd;
            end
            if (pen) begin
                #(bit_ns);
                w[8] = txd;
            end
            #(bit_ns);
            w[9] = txd;
            got.push_back(w);
        end
    end
    // Send one frame with the given parity and stop level
    task automatic send(input logic [7:0] c, input logic p, input logic s);
        rxd = 1'b0;
        #(bit_ns);
        for (int i = 0; i < nbits; i++) begin
            rxd = c[i];
            #(bit_ns);
        end
        if (pen) begin
            rxd = p;
            #(bit_ns);
        end
        rxd = s;
        #(bit_ns);
        rxd = 1'b1;
        #(2.0 * bit_ns);
    endtask
endmodule // fbu_host
`default_nettype wire

// [test_fractional_baud_uart.sv]
`default_nettype none
module test_fractional_baud_uart;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, txd, irq, rxd, err, pb;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] lfsr = 32'h5ab94fee;
    logic [9:0] w;
    logic [7:0] c, ov[5];
    logic [6:0] cf;
    logic [15:0] dv;

    fbu_uart fbu_uart_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
        .txd(txd), .irq(irq));
    fbu_host fbu_host_i (.txd(txd), .rxd(rxd));

    // 10 MHz clock and a hang guard
    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 80000) begin
            fail_count++;
            give_verdict();
        end
    end

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // Expected parity bit: odd, even, mark, space
    function automatic logic par(logic [7:0] d, logic l7, logic [1:0] t);
        logic x;
        x = l7 ? ^d[6:0] : ^d;
        return t[1] ? ~t[0] : (t[0] ? x : ~x);
    endfunction

    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // One APB transfer; held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) fail_count++;
    endtask
    task automatic rdchk(input string what, input logic [7:0] a,
                         input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(what, rd, e);
    endtask
    task automatic wait_tx();
        int n;
        n = 0;
        while (fbu_host_i.got.size() == 0 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (n == 3000) fail_count++;
        else w = fbu_host_i.got.pop_front();
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge pclk);
        check("irq", 32'(irq), 32'(e));
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and an unmapped address
        rdchk("ctrl", 8'h04, 32'h0);
        rdchk("baud", 8'h08, 32'h40);
        rdchk("ien", 8'h10, 32'h0);
        rdchk("status", 8'h0c, 32'h10);
        apb(1'b0, 8'h14, 32'h0);
        check("slverr", 32'(err), 32'h1);
        // Every reference and parity kind, random divider and format
        for (int k = 0; k < 16; k++) begin
            dv = 16'h0040 + 16'(rnd() & 32'hf);
            cf = {1'(rnd()), 2'(k >> 2), k != 5, 1'(rnd()), 2'(k)};
            apb(1'b1, 8'h08, {16'h0, dv});
            apb(1'b1, 8'h04, {25'h0, cf});
            fbu_host_i.bit_ns = real'(dv) * 12.5 * (1 << cf[1:0]);
            fbu_host_i.nbits = cf[2] ? 7 : 8;
            fbu_host_i.pen = cf[3];
            c = 8'(rnd());
            apb(1'b1, 8'h00, {24'h0, c});
            wait_tx();
            check("tx data", 32'(w[7:0]), 32'(c & {~cf[2], 7'h7f}));
            pb = par(c, cf[2], cf[5:4]);
            if (cf[3]) check("tx par", 32'(w[8]), 32'(pb));
            check("tx stop", 32'(w[9]), 32'h1);
            c = 8'(rnd());
            fbu_host_i.send(c, par(c, cf[2], cf[5:4]), 1'b1);
            rdchk("rx count", 8'h0c, 32'h11);
            rdchk("rx data", 8'h00, 32'(c & {~cf[2], 7'h7f}));
        end
        // Receive errors, flags, interrupts
        apb(1'b1, 8'h08, 32'h40);
        apb(1'b1, 8'h04, 32'h18);
        apb(1'b1, 8'h10, 32'he);
        fbu_host_i.bit_ns = 800.0;
        fbu_host_i.nbits = 8;
        fbu_host_i.pen = 1'b1;
        fbu_host_i.send(8'h5a, 1'b1, 1'b1);
        rdchk("parity err", 8'h0c, 32'h31);
        irq_is(1'b1);
        apb(1'b1, 8'h0c, 32'h20);
        irq_is(1'b0);
        rdchk("perr data", 8'h00, 32'h5a);
        fbu_host_i.send(8'h3c, 1'b0, 1'b0);
        rdchk("frame err", 8'h0c, 32'h51);
        apb(1'b1, 8'h0c, 32'h40);
        rdchk("ferr data", 8'h00, 32'h3c);
        for (int i = 0; i < 5; i++) begin
            ov[i] = 8'(rnd());
            fbu_host_i.send(ov[i], par(ov[i], 1'b0, 2'h1), 1'b1);
        end
        rdchk("overrun", 8'h0c, 32'h94);
        apb(1'b1, 8'h10, 32'h1);
        apb(1'b1, 8'h0c, 32'h80);
        irq_is(1'b1);
        for (int i = 0; i < 4; i++) rdchk("fifo", 8'h00, 32'(ov[i]));
        irq_is(1'b0);
        rdchk("drained", 8'h0c, 32'h10);
        give_verdict();
    end
endmodule // test_fractional_baud_uart
`default_nettype wire
